// ---- core/alos_core.sv ----
// Purpose: Executes the pointer-add, AND, add, add-with-carry and shift subset of the core.
// Assumes: One clock; software drives operations through the command register.
// Notes:   Writing the command register executes it in the cycle the write completes.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "alos_regs.svh"

module alos_core (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire alos_pkg::alos_axi_req_t axiReq,
    output      alos_pkg::alos_axi_rsp_t axiRsp
);
    import alos_pkg::*;

    alos_state_t s_q;
    alos_state_t s_d;
    logic        awTake;
    logic        wTake;
    logic        haveAw;
    logic        haveW;
    logic [11:0] wAddr;
    logic [31:0] wDataNow;
    logic [3:0]  wStrbNow;
    logic        exec;
    alos_op_t    exOp;
    logic        exDest;
    logic        exSel;
    logic [6:0]  exAddr;
    logic [7:0]  exImm;
    logic [7:0]  fVal;
    logic [15:0] selPtr;
    alos_alu_t   alu;
    logic [31:0] rdWord;
    logic        rdOk;

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers.

    // Zero test of an 8-bit result.
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == 8'h00);
    endfunction

    // 8-bit add with carry in; carry and nibble flags come from bit 7 and bit 3 carries, zero from the result.
    function automatic alos_alu_t add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        add8.result            = full[7:0];
        add8.carry             = full[8];
        add8.nibbleOverflowBit = low[4];
        add8.zero              = isZero(full[7:0]);
    endfunction

    // Byte-lane merge of a bus write into an old word.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        mergeBytes = old;
    endfunction

    // Word-aligned form of a byte address.
    function automatic logic [11:0] wordAddr(input logic [11:0] a);
        wordAddr = {a[11:2], 2'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, register writes and execution.

    always_comb begin
        s_d      = s_q;
        awTake   = axiReq.awvalid & s_q.rsp.awready;
        wTake    = axiReq.wvalid & s_q.rsp.wready;
        haveAw   = s_q.awHeld | awTake;
        haveW    = s_q.wHeld | wTake;
        wAddr    = s_q.awHeld ? s_q.awAddr : axiReq.awaddr;
        wDataNow = s_q.wHeld ? s_q.wData : axiReq.wdata;
        wStrbNow = s_q.wHeld ? s_q.wStrb : axiReq.wstrb;
        exec     = 1'b0;
        alu      = '0;
        rdWord   = 32'h0000_0000;
        rdOk     = 1'b1;

        // Address and data may arrive in either order; the first one waits here.
        if (awTake) begin
            s_d.awHeld      = 1'b1;
            s_d.awAddr      = axiReq.awaddr;
            s_d.rsp.awready = 1'b0;
        end
        if (wTake) begin
            s_d.wHeld      = 1'b1;
            s_d.wData      = axiReq.wdata;
            s_d.wStrb      = axiReq.wstrb;
            s_d.rsp.wready = 1'b0;
        end

        // Readies come back only after the response is taken, so one write at a time.
        if (s_q.rsp.bvalid && axiReq.bready) begin
            s_d.rsp.bvalid  = 1'b0;
            s_d.rsp.awready = 1'b1;
            s_d.rsp.wready  = 1'b1;
        end

        // Both halves present: perform the write and raise the response.
        if (haveAw && haveW) begin
            s_d.awHeld    = 1'b0;
            s_d.wHeld     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = `ALOS_RESP_OKAY;
            if (wordAddr(wAddr) == `ALOS_OFF_CMD) begin
                s_d.cmd = mergeBytes(s_q.cmd, wDataNow, wStrbNow);
                exec    = 1'b1;
            end else if (wordAddr(wAddr) == `ALOS_OFF_ACC) begin
                s_d.acc = wStrbNow[0] ? wDataNow[7:0] : s_q.acc;
            end else if (wordAddr(wAddr) == `ALOS_OFF_STAT) begin
                if (wStrbNow[0]) begin
                    s_d.carry             = wDataNow[`ALOS_STAT_C_BIT];
                    s_d.nibbleOverflowBit = wDataNow[`ALOS_STAT_NIB_BIT];
                    s_d.zero              = wDataNow[`ALOS_STAT_Z_BIT];
                end
            end else if (wordAddr(wAddr) == `ALOS_OFF_PTR0 ||
                         wordAddr(wAddr) == `ALOS_OFF_PTR1) begin
                s_d.indirectPointer[wAddr[4]] = 16'(mergeBytes({16'h0000,
                    s_q.indirectPointer[wAddr[4]]}, wDataNow, wStrbNow))
                    & `ALOS_PTR_MASK;
            end else if (wAddr >= `ALOS_OFF_FILE_LO && wAddr <= `ALOS_OFF_FILE_HI + 12'h003) begin
                if (wStrbNow[0]) begin
                    s_d.fileMem[wAddr[8:2]] = wDataNow[7:0];
                end
            end else begin
                s_d.rsp.bresp = `ALOS_RESP_SLVERR;
            end
        end

        // Command fields as they stand after this write.
        exOp   = alos_op_t'(s_d.cmd[`ALOS_CMD_OP_MSB:`ALOS_CMD_OP_LSB]);
        exDest = s_d.cmd[`ALOS_CMD_DEST_BIT];
        exSel  = s_d.cmd[`ALOS_CMD_SEL_BIT];
        exAddr = s_d.cmd[`ALOS_CMD_ADDR_MSB:`ALOS_CMD_ADDR_LSB];
        exImm  = s_d.cmd[`ALOS_CMD_IMM_MSB:`ALOS_CMD_IMM_LSB];
        fVal   = s_q.fileMem[exAddr];
        selPtr = s_q.indirectPointer[exSel];

        if (exec) begin
            case (exOp)
                ALOS_OP_POINTER_ADD_IMM: begin
                    s_d.indirectPointer[exSel] = (selPtr + {{10{exImm[5]}}, exImm[5:0]})
                        & `ALOS_PTR_MASK;
                end
                ALOS_OP_AND_IMMEDIATE: begin
                    alu.result = s_q.acc & exImm;
                    s_d.acc    = alu.result;
                    s_d.zero   = isZero(alu.result);
                end
                ALOS_OP_ADD_IMMEDIATE: begin
                    alu                   = add8(s_q.acc, exImm, 1'b0);
                    s_d.acc               = alu.result;
                    s_d.carry             = alu.carry;
                    s_d.nibbleOverflowBit = alu.nibbleOverflowBit;
                    s_d.zero              = alu.zero;
                end
                ALOS_OP_AND_REGISTER, ALOS_OP_ADD_REGISTER,
                ALOS_OP_SIGNED_RIGHT_SHIFT, ALOS_OP_ADD_REGISTER_CARRY_IN: begin
                    if (exOp == ALOS_OP_AND_REGISTER) begin
                        alu.result = s_q.acc & fVal;
                        alu.zero   = isZero(alu.result);
                    end else if (exOp == ALOS_OP_SIGNED_RIGHT_SHIFT) begin
                        alu.result = {fVal[7], fVal[7:1]};
                        alu.zero   = isZero(alu.result);
                        s_d.carry  = fVal[0];
                    end else begin
                        alu = add8(s_q.acc, fVal,
                                   exOp == ALOS_OP_ADD_REGISTER_CARRY_IN ? s_q.carry : 1'b0);
                        s_d.carry             = alu.carry;
                        s_d.nibbleOverflowBit = alu.nibbleOverflowBit;
                    end
                    s_d.zero = alu.zero;
                    if (exDest) begin
                        s_d.fileMem[exAddr] = alu.result;
                    end else begin
                        s_d.acc = alu.result;
                    end
                end
                default: begin
                    alu = '0;
                end
            endcase
        end

        // Read decode; unmapped addresses answer with an error and zero data.
        if (wordAddr(axiReq.araddr) == `ALOS_OFF_CMD) begin
            rdWord = s_q.cmd;
        end else if (wordAddr(axiReq.araddr) == `ALOS_OFF_ACC) begin
            rdWord = {24'h000000, s_q.acc};
        end else if (wordAddr(axiReq.araddr) == `ALOS_OFF_STAT) begin
            rdWord = {29'h00000000, s_q.zero, s_q.nibbleOverflowBit, s_q.carry};
        end else if (wordAddr(axiReq.araddr) == `ALOS_OFF_PTR0 ||
                     wordAddr(axiReq.araddr) == `ALOS_OFF_PTR1) begin
            rdWord = {16'h0000, s_q.indirectPointer[axiReq.araddr[4]]};
        end else if (axiReq.araddr >= `ALOS_OFF_FILE_LO &&
                     axiReq.araddr <= `ALOS_OFF_FILE_HI + 12'h003) begin
            rdWord = {24'h000000, s_q.fileMem[axiReq.araddr[8:2]]};
        end else begin
            rdOk = 1'b0;
        end

        // Read channel: answer one cycle after the address is taken.
        if (axiReq.arvalid && s_q.rsp.arready) begin
            s_d.rsp.arready = 1'b0;
            s_d.rsp.rvalid  = 1'b1;
            s_d.rsp.rdata   = rdWord;
            s_d.rsp.rresp   = rdOk ? `ALOS_RESP_OKAY : `ALOS_RESP_SLVERR;
        end else if (s_q.rsp.rvalid && axiReq.rready) begin
            s_d.rsp.rvalid  = 1'b0;
            s_d.rsp.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; readies are high from reset so the first request is taken at once.

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q             <= '0;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready  <= 1'b1;
            s_q.rsp.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign axiRsp = s_q.rsp;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the executed operations.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ptr_add;
        exec && exOp == ALOS_OP_POINTER_ADD_IMM |=>
            s_q.indirectPointer[$past(exSel)] == (($past(selPtr) +
            {{10{$past(exImm[5])}}, $past(exImm[5:0])}) & `ALOS_PTR_MASK) &&
            $stable({s_q.carry, s_q.nibbleOverflowBit, s_q.zero});
    endproperty
    a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

    property p_ptr_bound;
        ((s_q.indirectPointer[0] | s_q.indirectPointer[1]) & ~`ALOS_PTR_MASK) == 16'h0000;
    endproperty
    a_ptr_bound: assert property (p_ptr_bound) else $error("pointer out of range");

    property p_and_imm;
        exec && exOp == ALOS_OP_AND_IMMEDIATE |=> s_q.acc == $past(s_q.acc & exImm) &&
            $stable({s_q.carry, s_q.nibbleOverflowBit}) && s_q.zero == (s_q.acc == 8'h00);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

    property p_add_imm;
        exec && exOp == ALOS_OP_ADD_IMMEDIATE |=>
            {s_q.carry, s_q.acc} == $past({1'b0, s_q.acc} + {1'b0, exImm});
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

    property p_and_reg;
        exec && exOp == ALOS_OP_AND_REGISTER && !exDest |=>
            s_q.acc == $past(s_q.acc & fVal) && $stable(s_q.carry);
    endproperty
    a_and_reg: assert property (p_and_reg) else $error("and register wrong");

    property p_dest_file;
        exec && exDest && exOp >= ALOS_OP_AND_REGISTER |=> $stable(s_q.acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("accumulator hit on dest 1");

    property p_add_reg;
        exec && exOp == ALOS_OP_ADD_REGISTER && exDest |=>
            {s_q.carry, s_q.fileMem[$past(exAddr)]} == $past({1'b0, s_q.acc} + {1'b0, fVal});
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add register wrong");

    property p_shift;
        exec && exOp == ALOS_OP_SIGNED_RIGHT_SHIFT && !exDest |=>
            s_q.carry == $past(fVal[0]) && s_q.acc == $past({fVal[7], fVal[7:1]});
    endproperty
    a_shift: assert property (p_shift) else $error("signed shift wrong");

    property p_add_carry;
        exec && exOp == ALOS_OP_ADD_REGISTER_CARRY_IN && !exDest |=> {s_q.carry, s_q.acc} ==
            $past({1'b0, s_q.acc} + {1'b0, fVal} + {8'h00, s_q.carry});
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

    property p_nibble;
        exec && exOp == ALOS_OP_ADD_IMMEDIATE |=> s_q.nibbleOverflowBit ==
            $past(({1'b0, s_q.acc[3:0]} + {1'b0, exImm[3:0]}) > 5'h0f) &&
            s_q.zero == (s_q.acc == 8'h00);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble or zero flag wrong");

    property p_ptr_wrap;
        exec && exOp == ALOS_OP_POINTER_ADD_IMM && selPtr == 16'h0000 && exImm[5];
    endproperty
    c_ptr_wrap: cover property (p_ptr_wrap);

    property p_carry_in;
        exec && exOp == ALOS_OP_ADD_REGISTER_CARRY_IN && s_q.carry;
    endproperty
    c_carry_in: cover property (p_carry_in);

    property p_shift_file;
        exec && exOp == ALOS_OP_SIGNED_RIGHT_SHIFT && exDest;
    endproperty
    c_shift_file: cover property (p_shift_file);

endmodule

// ---- core/alos_regs.svh ----
// Purpose: Register map, field positions, reset values and flag layout of the ALU subset.
// Assumes: AXI4-Lite slave with a 12-bit byte address and 32-bit data.
// Notes:   Behaviour of the block, one line per item:
// Behaviour
// - Pointer add sign-extends a 6-bit immediate into a selected pointer; no flags change.
// - Pointers stay within 0000h..FFFh and wrap around at either bound.
// - AND-immediate puts accumulator AND immediate into accumulator; only zero changes.
// - Add-immediate puts accumulator plus immediate into accumulator; carry, nibble, zero.
// - AND-register ANDs accumulator with file register 0..127; only zero changes.
// - Register operations write the accumulator when dest is 0, the file register when 1.
// - Add-register adds accumulator and file register; carry, nibble and zero change.
// - Signed shift moves bits 7:1 down, keeps bit 7, old bit 0 into carry.
// - Add-with-carry sums accumulator, file register and carry; carry, nibble, zero.
`ifndef ALOS_REGS_SVH
`define ALOS_REGS_SVH

// Register byte offsets.
`define ALOS_OFF_CMD       12'h000
`define ALOS_OFF_ACC       12'h004
`define ALOS_OFF_STAT      12'h008
`define ALOS_OFF_PTR0      12'h00c
`define ALOS_OFF_PTR1      12'h010
`define ALOS_OFF_FILE_LO   12'h200
`define ALOS_OFF_FILE_HI   12'h3fc

// Command word fields.
`define ALOS_CMD_OP_LSB    0
`define ALOS_CMD_OP_MSB    3
`define ALOS_CMD_DEST_BIT  4
`define ALOS_CMD_SEL_BIT   5
`define ALOS_CMD_ADDR_LSB  8
`define ALOS_CMD_ADDR_MSB  14
`define ALOS_CMD_IMM_LSB   16
`define ALOS_CMD_IMM_MSB   23

// Status word bits.
`define ALOS_STAT_C_BIT    0
`define ALOS_STAT_NIB_BIT  1
`define ALOS_STAT_Z_BIT    2

// Pointer bound and reset values.
`define ALOS_PTR_MASK      16'h0fff
`define ALOS_CMD_RST       32'h0000_0000
`define ALOS_ACC_RST       8'h00
`define ALOS_PTR_RST       16'h0000

// Bus responses.
`define ALOS_RESP_OKAY     2'h0
`define ALOS_RESP_SLVERR   2'h2

`endif

// ---- core/alos_pkg.sv ----
// Purpose: Types shared by the ALU subset datapath.
// Assumes: Encodings of the command field are local to this block.
// Notes:   Bus channels travel as packed structs with published AXI signal names.
package alos_pkg;

    // Operation codes carried in the command word.
    typedef enum logic [3:0] {
        ALOS_OP_NOP                   = 4'h0,
        ALOS_OP_POINTER_ADD_IMM       = 4'h1,
        ALOS_OP_AND_IMMEDIATE         = 4'h2,
        ALOS_OP_ADD_IMMEDIATE         = 4'h3,
        ALOS_OP_AND_REGISTER          = 4'h4,
        ALOS_OP_ADD_REGISTER          = 4'h5,
        ALOS_OP_SIGNED_RIGHT_SHIFT    = 4'h6,
        ALOS_OP_ADD_REGISTER_CARRY_IN = 4'h7
    } alos_op_t;

    // Master to slave signals.
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } alos_axi_req_t;

    // Slave to master signals.
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } alos_axi_rsp_t;

    // Result of one arithmetic or logic step.
    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       nibbleOverflowBit;
        logic       zero;
    } alos_alu_t;

    // Whole state of the datapath.
    typedef struct packed {
        alos_axi_rsp_t         rsp;
        logic                  awHeld;
        logic [11:0]           awAddr;
        logic                  wHeld;
        logic [31:0]           wData;
        logic [3:0]            wStrb;
        logic [31:0]           cmd;
        logic [7:0]            acc;
        logic                  carry;
        logic                  nibbleOverflowBit;
        logic                  zero;
        logic [1:0][15:0]      indirectPointer;
        logic [127:0][7:0]     fileMem;
    } alos_state_t;

endpackage

// ---- sim/test_arith_logic_op_subset.sv ----
// Purpose: Self-checking bench for the ALU subset, driven over its AXI4-Lite register bus.
// Assumes: Offsets, command layout and status bits as declared in alos_regs.svh.
// Notes:   Expected values are worked out by hand from the operation rules.
`timescale 1ns/1ps
`include "alos_regs.svh"

module test_arith_logic_op_subset;
    import alos_pkg::*;

    logic          ref_clk = 1'b0;
    logic          rst_n;
    alos_axi_req_t axiReq;
    alos_axi_rsp_t axiRsp;
    int            n_mismatch;
    int            n_checks;
    logic [31:0]   rd;

    // Free-running 125 MHz clock.
    always #4 ref_clk = ~ref_clk;

    alos_core dut (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .axiReq  (axiReq),
        .axiRsp  (axiRsp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Four-state compare, so an unknown never passes for a match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // A bus wait that runs out is a mismatch and closes the run.
    task automatic hang(input string what);
        n_mismatch++;
        $display("BAD %0t no answer to %s", $time, what);
        summarize();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Write cycle: address and data offered together, each dropped when taken.
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int         k;
        logic [1:0] r;
        @(posedge ref_clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr  <= a;
        axiReq.wvalid  <= 1'b1;
        axiReq.wdata   <= d;
        axiReq.wstrb   <= 4'hf;
        axiReq.bready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid) begin
                r = axiRsp.bresp;
                axiReq.bready <= 1'b0;
                break;
            end
        end
        if (k == 50) hang("write");
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask

    // Read cycle: rready is held until the data beat is sampled.
    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        int         k;
        logic [1:0] r;
        @(posedge ref_clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= a;
        axiReq.rready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid) begin
                d = axiRsp.rdata;
                r = axiRsp.rresp;
                axiReq.rready <= 1'b0;
                break;
            end
        end
        if (k == 50) hang("read");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus_wr(a, d, `ALOS_RESP_OKAY);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus_rd(a, v, `ALOS_RESP_OKAY);
        chk(v, exp, what);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Loads accumulator, status and one file register, runs one command, checks all three.
    task automatic run_op(input logic [7:0] acc0, input logic [7:0] st0, input logic [7:0] f0,
                          input logic [3:0] op, input logic dest, input logic [6:0] fa,
                          input logic [7:0] imm, input logic [7:0] eAcc, input logic [7:0] eSt,
                          input logic [7:0] eF);
        logic [11:0] fAddr;
        fAddr = `ALOS_OFF_FILE_LO + {3'h0, fa, 2'b00};
        wr(`ALOS_OFF_ACC, {24'h0, acc0});
        wr(`ALOS_OFF_STAT, {24'h0, st0});
        wr(fAddr, {24'h0, f0});
        wr(`ALOS_OFF_CMD, {8'h00, imm, 1'b0, fa, 2'b00, 1'b0, dest, op});
        rchk(`ALOS_OFF_ACC, {24'h0, eAcc}, "accumulator");
        rchk(`ALOS_OFF_STAT, {24'h0, eSt}, "status");
        rchk(fAddr, {24'h0, eF}, "file register");
    endtask

    // Pointer add; status is preset to a mixed pattern that must survive untouched.
    task automatic ptr_op(input logic sel, input logic [5:0] k, input logic [15:0] p0,
                          input logic [15:0] exp);
        logic [11:0] pa;
        pa = sel ? `ALOS_OFF_PTR1 : `ALOS_OFF_PTR0;
        wr(pa, {16'h0, p0});
        wr(`ALOS_OFF_STAT, 32'h0000_0005);
        wr(`ALOS_OFF_CMD, {8'h00, 2'b00, k, 8'h00, 2'b00, sel, 1'b0, 4'h1});
        rchk(pa, {16'h0, exp}, "pointer");
        rchk(`ALOS_OFF_STAT, 32'h0000_0005, "status after pointer add");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, register defaults, every operation, then a second reset.
    initial begin
        rst_n      = 1'b0;
        axiReq     = '0;
        n_mismatch = 0;
        n_checks   = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Defaults and an unmapped place.
        rchk(`ALOS_OFF_ACC, 32'h0, "accumulator reset");
        rchk(`ALOS_OFF_STAT, 32'h0, "status reset");
        rchk(`ALOS_OFF_PTR1, 32'h0, "pointer reset");
        bus_rd(12'h014, rd, `ALOS_RESP_SLVERR);
        chk(rd, 32'h0, "unmapped read data");
        bus_wr(12'h014, 32'h0000_00ff, `ALOS_RESP_SLVERR);
        ptr_op(1'b0, 6'h3a, 16'h0005, 16'h0fff);
        ptr_op(1'b1, 6'h1f, 16'h0ffe, 16'h001d);
        ptr_op(1'b1, 6'h20, 16'h001d, 16'h0ffd);
        ptr_op(1'b0, 6'h1f, 16'h0fff, 16'h001e);
        ptr_op(1'b0, 6'h3f, 16'h0000, 16'h0fff);
        rchk(`ALOS_OFF_PTR1, 32'h0000_0ffd, "unselected pointer");
        run_op(8'hf0, 8'h03, 8'h55, ALOS_OP_AND_IMMEDIATE, 1'b0, 7'd1, 8'h0f,
               8'h00, 8'h07, 8'h55);
        run_op(8'hff, 8'h04, 8'h55, ALOS_OP_AND_IMMEDIATE, 1'b0, 7'd1, 8'h81,
               8'h81, 8'h00, 8'h55);
        run_op(8'h88, 8'h04, 8'h00, ALOS_OP_ADD_IMMEDIATE, 1'b0, 7'd2, 8'h88,
               8'h10, 8'h03, 8'h00);
        run_op(8'h01, 8'h00, 8'h00, ALOS_OP_ADD_IMMEDIATE, 1'b0, 7'd2, 8'hff,
               8'h00, 8'h07, 8'h00);
        run_op(8'h0f, 8'h03, 8'h3c, ALOS_OP_AND_REGISTER, 1'b1, 7'd127, 8'h00,
               8'h0f, 8'h03, 8'h0c);
        run_op(8'h0f, 8'h03, 8'hf0, ALOS_OP_AND_REGISTER, 1'b0, 7'd64, 8'h00,
               8'h00, 8'h07, 8'hf0);
        run_op(8'hff, 8'h00, 8'h01, ALOS_OP_ADD_REGISTER, 1'b0, 7'd0, 8'h00,
               8'h00, 8'h07, 8'h01);
        run_op(8'h21, 8'h07, 8'h12, ALOS_OP_ADD_REGISTER, 1'b1, 7'd3, 8'h00,
               8'h21, 8'h00, 8'h33);
        run_op(8'h5a, 8'h00, 8'h81, ALOS_OP_SIGNED_RIGHT_SHIFT, 1'b1, 7'd5, 8'h00,
               8'h5a, 8'h01, 8'hc0);
        run_op(8'h5a, 8'h02, 8'h01, ALOS_OP_SIGNED_RIGHT_SHIFT, 1'b0, 7'd6, 8'h00,
               8'h00, 8'h07, 8'h01);
        run_op(8'h5a, 8'h05, 8'h7e, ALOS_OP_SIGNED_RIGHT_SHIFT, 1'b0, 7'd7, 8'h00,
               8'h3f, 8'h00, 8'h7e);
        run_op(8'h0e, 8'h01, 8'h01, ALOS_OP_ADD_REGISTER_CARRY_IN, 1'b1, 7'd10, 8'h00,
               8'h0e, 8'h02, 8'h10);
        run_op(8'hff, 8'h01, 8'h00, ALOS_OP_ADD_REGISTER_CARRY_IN, 1'b0, 7'd11, 8'h00,
               8'h00, 8'h07, 8'h00);
        run_op(8'hff, 8'h00, 8'h00, ALOS_OP_ADD_REGISTER_CARRY_IN, 1'b0, 7'd11, 8'h00,
               8'hff, 8'h00, 8'h00);
        // Second reset in mid-run clears the datapath again.
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(`ALOS_OFF_ACC, 32'h0, "accumulator after reset");
        rchk(`ALOS_OFF_FILE_HI, 32'h0, "file register after reset");
        summarize();
    end

endmodule
